// [logic/glue_pkg.sv]
// glue_pkg: shared constants and carrier types for the processor/cache glue
// assumes: one 10 MHz device clock, all straps sampled by the cache units themselves
package glue_pkg;

  // ==========================================================================
  // bus widths
  localparam int unsigned WORD_ADDR_W = 30;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned STATUS_W = 4;
  localparam int unsigned DEVICES = 3;
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================================
  // reply encoding on the two reply lines: 2'b11 is fault (pulled-high default)
  localparam logic [1:0] REPLY_FAULT = 2'h3;
  localparam logic [1:0] REPLY_WAIT = 2'h0;
  localparam logic [1:0] REPLY_SUCCESS = 2'h1;

  // ==========================================================================
  // identification base straps: {local_status, tag_monitor_bit0, trace_pins}
  localparam logic [6:0] ID_STRAP_INSN = 7'h0E;
  localparam logic [6:0] ID_STRAP_DATA = 7'h0F;
  localparam logic [31:0] ID_BASE_INSN = 32'hFFF7E000;
  localparam logic [31:0] ID_BASE_DATA = 32'hFFF7F000;

  // ==========================================================================
  // reset sequencing, in device clock cycles after synchronisation
  localparam logic [3:0] PLL_LEAD_CYCLES = 4'h8;
  localparam logic [3:0] STRAP_HOLD_CYCLES = 4'hF;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [LANES-1:0] byte_lane_enables;
    logic rd_wr;
    logic lock_n;
    logic cache_select_n;
  } cache_pbus_ctrl_type;

  typedef struct packed {
    logic [STATUS_W-1:0] local_status;
    logic tag_monitor_bit0;
    logic [1:0] trace_pins;
  } id_strap_type;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_INSN = 2'b01,
    ARB_DATA = 2'b10
  } arb_state_type;

endpackage

// [logic/sync_two_stage.sv]
// sync_two_stage: two flip-flop synchroniser for one asynchronous level
// assumes: clk_i is the shared device clock; rst_n_i is asynchronous
`timescale 1ns/1ps
module sync_two_stage #(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // level
  input wire logic async_i,
  output logic sync_o
);

  logic meta_q;
  logic sync_q;

  // both stages on the same rising edge; the first feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// [logic/cpu_cache_system_glue.sv]
// cpu_cache_system_glue: reset/pll generator, memory-bus arbiter, strap and reply glue
// assumes: comparator outputs arrive asynchronous; cache units drive requests on ref_clk_i
`timescale 1ns/1ps
module cpu_cache_system_glue (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // comparator levels, asynchronous
  input wire logic reset_ramp_ok_i,
  input wire logic pll_ramp_ok_i,
  // processor control toward the cache units
  input wire logic code_fetch_strobe_i,
  input wire logic [glue_pkg::LANES-1:0] byte_lane_enables_i,
  input wire logic data_rd_wr_i,
  input wire logic data_lock_n_i,
  input wire logic [glue_pkg::WORD_ADDR_W-1:0] data_word_addr_i,
  // reply lines from the cache units, with their enables
  input wire logic [1:0] data_reply_in_i,
  input wire logic data_reply_oe_i,
  input wire logic [1:0] code_reply_in_i,
  input wire logic code_reply_oe_i,
  // local status of each cache unit, active high
  input wire logic [glue_pkg::STATUS_W-1:0] insn_local_status_i,
  input wire logic [glue_pkg::STATUS_W-1:0] data_local_status_i,
  // memory-bus arbitration
  input wire logic insn_arb_request_i,
  input wire logic data_arb_request_i,
  input wire logic insn_bus_ack_i,
  input wire logic data_bus_ack_i,
  // reset and pll enable per device
  output logic [glue_pkg::DEVICES-1:0] rst_n_o,
  output logic [glue_pkg::DEVICES-1:0] pll_enable_out_o,
  // processor-bus qualification toward cache units
  output glue_pkg::cache_pbus_ctrl_type insn_pbus_ctrl_o,
  output glue_pkg::cache_pbus_ctrl_type data_pbus_ctrl_o,
  output logic [glue_pkg::WORD_ADDR_W-1:0] data_word_addr_o,
  // replies toward processor
  output logic data_reply_bit0_o,
  output logic data_reply_bit1_o,
  output logic code_reply_bit0_o,
  output logic code_reply_bit1_o,
  // identification straps
  output glue_pkg::id_strap_type insn_strap_o,
  output glue_pkg::id_strap_type data_strap_o,
  output logic strap_oe_o,
  // memory-bus arbitration results
  output logic insn_arb_grant_o,
  output logic data_arb_grant_o,
  output logic arbitration_busy_n_o,
  output logic bus_busy_n_o,
  output logic [glue_pkg::STATUS_W-1:0] system_status_n_o
);

  // ==========================================================================
  // reset release of the glue itself
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================================
  // comparator synchronisers
  logic reset_ok_s;
  logic pll_ok_s;

  sync_two_stage #(.RESET_VALUE(1'b0)) u_sync_reset (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .async_i(reset_ramp_ok_i),
    .sync_o(reset_ok_s)
  );

  sync_two_stage #(.RESET_VALUE(1'b0)) u_sync_pll (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .async_i(pll_ramp_ok_i),
    .sync_o(pll_ok_s)
  );

  // ==========================================================================
  // reset/pll sequencer
  // pll must be stable before any device leaves reset, so the lead is
  // enforced here even if the reset comparator trips first
  logic pll_en_q, pll_en_d;
  logic dev_rst_n_q, dev_rst_n_d;
  logic [3:0] lead_q, lead_d;
  logic [3:0] strap_q, strap_d;

  always_comb begin
    pll_en_d = pll_ok_s;
    lead_d = lead_q;
    dev_rst_n_d = dev_rst_n_q;
    strap_d = strap_q;
    if (!pll_en_q) begin
      lead_d = 4'h0;
    end else if (lead_q != glue_pkg::PLL_LEAD_CYCLES) begin
      lead_d = lead_q + 4'h1;
    end
    if (!(reset_ok_s && pll_en_q)) begin
      dev_rst_n_d = 1'b0;
    end else if (lead_q == glue_pkg::PLL_LEAD_CYCLES) begin
      dev_rst_n_d = 1'b1;
    end
    if (!dev_rst_n_q) begin
      strap_d = 4'h0;
    end else if (strap_q != glue_pkg::STRAP_HOLD_CYCLES) begin
      strap_d = strap_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_en_q <= 1'b0;
      lead_q <= 4'h0;
      dev_rst_n_q <= 1'b0;
      strap_q <= 4'h0;
    end else begin
      pll_en_q <= pll_en_d;
      lead_q <= lead_d;
      dev_rst_n_q <= dev_rst_n_d;
      strap_q <= strap_d;
    end
  end

  // one register fans out to three pins: identical release edge
  assign rst_n_o = {glue_pkg::DEVICES{dev_rst_n_q}};
  assign pll_enable_out_o = {glue_pkg::DEVICES{pll_en_q}};

  // ==========================================================================
  // straps: driven from reset through the hold window, then released
  logic strap_oe_q, strap_oe_d;

  always_comb begin
    strap_oe_d = !dev_rst_n_q || (strap_q != glue_pkg::STRAP_HOLD_CYCLES);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_oe_q <= 1'b1;
    end else begin
      strap_oe_q <= strap_oe_d;
    end
  end

  assign strap_oe_o = strap_oe_q;
  assign insn_strap_o = glue_pkg::ID_STRAP_INSN;
  assign data_strap_o = glue_pkg::ID_STRAP_DATA;

  // ==========================================================================
  // processor-bus qualification, registered (one cycle of latency)
  glue_pkg::cache_pbus_ctrl_type insn_ctrl_q, insn_ctrl_d;
  glue_pkg::cache_pbus_ctrl_type data_ctrl_q, data_ctrl_d;
  logic [glue_pkg::WORD_ADDR_W-1:0] addr_q, addr_d;
  logic [3:0] reply_q, reply_d;

  always_comb begin
    insn_ctrl_d.byte_lane_enables = {glue_pkg::LANES{code_fetch_strobe_i}};
    insn_ctrl_d.rd_wr = 1'b1;
    insn_ctrl_d.lock_n = 1'b1;
    insn_ctrl_d.cache_select_n = 1'b0;
    data_ctrl_d.byte_lane_enables = byte_lane_enables_i;
    data_ctrl_d.rd_wr = data_rd_wr_i;
    data_ctrl_d.lock_n = data_lock_n_i;
    data_ctrl_d.cache_select_n = 1'b0;
    addr_d = data_word_addr_i;
    // undriven reply lines read as fault; wait and success pass untouched
    reply_d[1:0] = data_reply_oe_i ? data_reply_in_i : glue_pkg::REPLY_FAULT;
    reply_d[3:2] = code_reply_oe_i ? code_reply_in_i : glue_pkg::REPLY_FAULT;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      insn_ctrl_q <= '{byte_lane_enables: 4'h0, rd_wr: 1'b1, lock_n: 1'b1, cache_select_n: 1'b0};
      data_ctrl_q <= '{byte_lane_enables: 4'h0, rd_wr: 1'b1, lock_n: 1'b1, cache_select_n: 1'b0};
      addr_q <= '0;
      reply_q <= 4'hF;
    end else begin
      insn_ctrl_q <= insn_ctrl_d;
      data_ctrl_q <= data_ctrl_d;
      addr_q <= addr_d;
      reply_q <= reply_d;
    end
  end

  assign insn_pbus_ctrl_o = insn_ctrl_q;
  assign data_pbus_ctrl_o = data_ctrl_q;
  assign data_word_addr_o = addr_q;
  assign data_reply_bit0_o = reply_q[0];
  assign data_reply_bit1_o = reply_q[1];
  assign code_reply_bit0_o = reply_q[2];
  assign code_reply_bit1_o = reply_q[3];

  // ==========================================================================
  // memory-bus arbiter and system status
  // grants and busy are decoded before the flops so no decode glitch reaches a pin
  glue_pkg::arb_state_type arb_d;
  logic insn_grant_q, insn_grant_d;
  logic data_grant_q, data_grant_d;
  logic ab_n_q, ab_n_d;
  logic bb_n_q, bb_n_d;
  logic [glue_pkg::STATUS_W-1:0] ss_n_q, ss_n_d;

  always_comb begin
    arb_d = glue_pkg::ARB_IDLE;
    if (insn_arb_request_i) begin
      arb_d = glue_pkg::ARB_INSN;
    end else if (data_arb_request_i) begin
      arb_d = glue_pkg::ARB_DATA;
    end
    unique case (arb_d)
      glue_pkg::ARB_INSN: begin
        insn_grant_d = 1'b1;
        data_grant_d = 1'b0;
      end
      glue_pkg::ARB_DATA: begin
        insn_grant_d = 1'b0;
        data_grant_d = 1'b1;
      end
      default: begin
        insn_grant_d = 1'b0;
        data_grant_d = 1'b0;
      end
    endcase
    ab_n_d = (arb_d == glue_pkg::ARB_IDLE);
    bb_n_d = !(insn_bus_ack_i || data_bus_ack_i);
    ss_n_d = ~(insn_local_status_i | data_local_status_i);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      insn_grant_q <= 1'b0;
      data_grant_q <= 1'b0;
      ab_n_q <= 1'b1;
      bb_n_q <= 1'b1;
      ss_n_q <= 4'hF;
    end else begin
      insn_grant_q <= insn_grant_d;
      data_grant_q <= data_grant_d;
      ab_n_q <= ab_n_d;
      bb_n_q <= bb_n_d;
      ss_n_q <= ss_n_d;
    end
  end

  assign insn_arb_grant_o = insn_grant_q;
  assign data_arb_grant_o = data_grant_q;
  assign arbitration_busy_n_o = ab_n_q;
  assign bus_busy_n_o = bb_n_q;
  assign system_status_n_o = ss_n_q;

endmodule

// [tb/glue_checker.sv]
// glue_checker: port-level timing checks for the processor/cache glue
// assumes: bound to cpu_cache_system_glue, one device clock
`timescale 1ns/1ps
module glue_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // inputs watched
  input wire logic pll_ramp_ok_i,
  input wire logic code_fetch_strobe_i,
  input wire logic [glue_pkg::LANES-1:0] byte_lane_enables_i,
  input wire logic data_rd_wr_i,
  input wire logic data_lock_n_i,
  input wire logic [glue_pkg::WORD_ADDR_W-1:0] data_word_addr_i,
  input wire logic [1:0] data_reply_in_i,
  input wire logic data_reply_oe_i,
  input wire logic [1:0] code_reply_in_i,
  input wire logic code_reply_oe_i,
  input wire logic [glue_pkg::STATUS_W-1:0] insn_local_status_i,
  input wire logic [glue_pkg::STATUS_W-1:0] data_local_status_i,
  input wire logic insn_arb_request_i,
  input wire logic data_arb_request_i,
  input wire logic insn_bus_ack_i,
  input wire logic data_bus_ack_i,
  // outputs watched
  input wire logic [glue_pkg::DEVICES-1:0] rst_n_o,
  input wire logic [glue_pkg::DEVICES-1:0] pll_enable_out_o,
  input wire glue_pkg::cache_pbus_ctrl_type insn_pbus_ctrl_o,
  input wire glue_pkg::cache_pbus_ctrl_type data_pbus_ctrl_o,
  input wire logic [glue_pkg::WORD_ADDR_W-1:0] data_word_addr_o,
  input wire logic data_reply_bit0_o,
  input wire logic data_reply_bit1_o,
  input wire logic code_reply_bit0_o,
  input wire logic code_reply_bit1_o,
  input wire logic insn_arb_grant_o,
  input wire logic data_arb_grant_o,
  input wire logic arbitration_busy_n_o,
  input wire logic bus_busy_n_o,
  input wire logic [glue_pkg::STATUS_W-1:0] system_status_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================================
  // reset sequencing
  property p_sync; $rose(pll_enable_out_o[0]) |-> $past(pll_ramp_ok_i, 2); endproperty
  a_sync: assert property (p_sync) else $error("pll enable rose too early");
  property p_lead; $rose(rst_n_o[0]) |-> $past(pll_enable_out_o[0], 9); endproperty
  a_lead: assert property (p_lead) else $error("reset left before pll lead");
  property p_fanout; rst_n_o inside {3'h0, 3'h7} && pll_enable_out_o inside {3'h0, 3'h7}; endproperty
  a_fanout: assert property (p_fanout) else $error("device copies differ");
  // ==========================================================================
  // arbitration
  property p_arb_insn; insn_arb_request_i |=> insn_arb_grant_o && !data_arb_grant_o
    && !arbitration_busy_n_o; endproperty
  a_arb_insn: assert property (p_arb_insn) else $error("insn grant wrong");
  property p_arb_data; data_arb_request_i && !insn_arb_request_i |=> data_arb_grant_o && !insn_arb_grant_o
    && !arbitration_busy_n_o; endproperty
  a_arb_data: assert property (p_arb_data) else $error("data grant wrong");
  property p_arb_idle; !insn_arb_request_i && !data_arb_request_i |=> arbitration_busy_n_o
    && !insn_arb_grant_o && !data_arb_grant_o; endproperty
  a_arb_idle: assert property (p_arb_idle) else $error("grant without request");
  property p_bus_busy; 1'b1 |=> bus_busy_n_o == !($past(insn_bus_ack_i) || $past(data_bus_ack_i)); endproperty
  a_bus_busy: assert property (p_bus_busy) else $error("bus busy wrong");
  property p_status; 1'b1 |=> system_status_n_o == ~($past(insn_local_status_i) | $past(data_local_status_i));
  endproperty
  a_status: assert property (p_status) else $error("system status wrong");
  // ==========================================================================
  // processor-bus glue
  property p_code; 1'b1 |=> insn_pbus_ctrl_o == {{4{$past(code_fetch_strobe_i)}}, 3'h6}; endproperty
  a_code: assert property (p_code) else $error("insn qualifiers wrong");
  property p_reply; 1'b1 |=> {data_reply_bit1_o, data_reply_bit0_o} == ($past(data_reply_oe_i)
    ? $past(data_reply_in_i) : glue_pkg::REPLY_FAULT); endproperty
  a_reply: assert property (p_reply) else $error("reply wrong");
  property p_code_reply; 1'b1 |=> {code_reply_bit1_o, code_reply_bit0_o} == ($past(code_reply_oe_i)
    ? $past(code_reply_in_i) : glue_pkg::REPLY_FAULT); endproperty
  a_code_reply: assert property (p_code_reply) else $error("code reply wrong");
  property p_data; 1'b1 |=> data_word_addr_o == $past(data_word_addr_i) && data_pbus_ctrl_o
    == {$past(byte_lane_enables_i), $past(data_rd_wr_i), $past(data_lock_n_i), 1'b0}; endproperty
  a_data: assert property (p_data) else $error("data bus wrong");
endmodule
bind cpu_cache_system_glue glue_checker i_glue_checker (.ref_clk_i, .arst_n_i, .pll_ramp_ok_i,
  .code_fetch_strobe_i, .data_lock_n_i, .data_word_addr_i, .data_reply_in_i, .data_reply_oe_i,
  .insn_local_status_i, .data_local_status_i, .insn_arb_request_i, .data_arb_request_i, .insn_bus_ack_i,
  .data_bus_ack_i, .rst_n_o, .pll_enable_out_o, .insn_pbus_ctrl_o, .data_pbus_ctrl_o, .data_word_addr_o,
  .data_reply_bit0_o, .data_reply_bit1_o, .insn_arb_grant_o, .data_arb_grant_o, .arbitration_busy_n_o,
  .bus_busy_n_o, .system_status_n_o, .byte_lane_enables_i, .data_rd_wr_i, .code_reply_in_i,
  .code_reply_oe_i, .code_reply_bit0_o, .code_reply_bit1_o);

// [tb/cache_units_model.sv]
// cache_units_model: bus acknowledge and data-side replies of the cache units
// assumes: same clock as the glue; bench commands each reply and its wait count
`timescale 1ns/1ps
module cache_units_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // grants and commands
  input wire logic [1:0] grant_i,
  input wire logic start_i,
  input wire logic [2:0] waits_i,
  // toward the glue
  output logic [1:0] ack_o,
  output logic [1:0] reply_o,
  output logic reply_oe_o
);
  logic [1:0] ack_d, ack_q;
  logic [3:0] cnt_d, cnt_q;
  always_comb begin
    ack_d = grant_i; // master one cycle after its grant
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    if (start_i) begin
      cnt_d = {1'b0, waits_i} + 4'h1; // zero to seven waits before success
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 2'h0;
      cnt_q <= 4'h0;
    end else begin
      ack_q <= ack_d;
      cnt_q <= cnt_d;
    end
  end
  assign ack_o = ack_q;
  assign reply_oe_o = (cnt_q != 4'h0);
  // released lines float to the pull-up level, which reads as fault
  assign reply_o = (cnt_q == 4'h1) ? glue_pkg::REPLY_SUCCESS : (cnt_q != 4'h0) ? glue_pkg::REPLY_WAIT
    : glue_pkg::REPLY_FAULT;
endmodule

// [tb/test_cpu_cache_system_glue.sv]
// test_cpu_cache_system_glue: reset sequencing, arbitration and replies
// assumes: checker bound to the glue; cache units modelled beside it
`timescale 1ns/1ps
module test_cpu_cache_system_glue;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pll_ok = 1'b0, rst_ok = 1'b0, cfs = 1'b0, rdwr = 1'b1, lock_n = 1'b1, ireq = 1'b0, dreq = 1'b0;
  logic start = 1'b0;
  logic [2:0] waits = 3'h0;
  logic [1:0] crep = 2'h0;
  logic croe = 1'b0;
  logic [3:0] lanes = 4'h0, ils = 4'h0, dls = 4'h0;
  logic [29:0] addr = 30'h0;
  logic [2:0] rst_n, pll;
  logic [1:0] ack, rep, r;
  logic rep_oe, ig, dg, db0, db1, soe;
  glue_pkg::id_strap_type istrap, dstrap;
  logic [1:0] gq[$];
  logic [1:0] rq[$];
  int err_count = 0;
  int comparisons = 0;
  int n;
  always #50 ref_clk_i = ~ref_clk_i;
  cpu_cache_system_glue i_cpu_cache_system_glue (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .reset_ramp_ok_i(rst_ok), .pll_ramp_ok_i(pll_ok), .code_fetch_strobe_i(cfs), .byte_lane_enables_i(lanes),
    .data_rd_wr_i(rdwr), .data_lock_n_i(lock_n), .data_word_addr_i(addr), .data_reply_in_i(rep),
    .data_reply_oe_i(rep_oe), .code_reply_in_i(crep), .code_reply_oe_i(croe), .insn_local_status_i(ils),
    .data_local_status_i(dls), .insn_arb_request_i(ireq), .data_arb_request_i(dreq), .insn_bus_ack_i(ack[1]),
    .data_bus_ack_i(ack[0]), .rst_n_o(rst_n), .pll_enable_out_o(pll), .insn_pbus_ctrl_o(), .data_pbus_ctrl_o(),
    .data_word_addr_o(), .data_reply_bit0_o(db0), .data_reply_bit1_o(db1), .code_reply_bit0_o(),
    .code_reply_bit1_o(), .insn_strap_o(istrap), .data_strap_o(dstrap), .strap_oe_o(soe),
    .insn_arb_grant_o(ig), .data_arb_grant_o(dg), .arbitration_busy_n_o(), .bus_busy_n_o(),
    .system_status_n_o());
  cache_units_model i_cache_units_model (.clk_i(ref_clk_i), .rst_n_i(rst_n[1]), .grant_i({ig, dg}),
    .start_i(start), .waits_i(waits), .ack_o(ack), .reply_o(rep), .reply_oe_o(rep_oe));
  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step;
    @(posedge ref_clk_i);
    {cfs, rdwr, lock_n, lanes, ils, dls} <= 15'($urandom);
    addr <= 30'($urandom);
    {crep, croe} <= 3'($urandom);
  endtask
  // counts settled cycles until the chosen output reaches its level
  task automatic span(input int sel, output int k);
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (k < 40 && (sel == 0 ? pll !== 3'h7 : sel == 1 ? rst_n !== 3'h7 : soe !== 1'b0));
  endtask
  // ==========================================================================
  // result watcher
  always @(negedge ref_clk_i) begin
    if ({ig, dg} !== 2'h0) begin
      check({ig, dg}, gq.size() ? gq.pop_front() : 2'hX);
    end
    if ({db1, db0} !== glue_pkg::REPLY_FAULT) begin
      check({db1, db0}, rq.size() ? rq.pop_front() : 2'hX);
    end
  end
  initial begin
    #2000000;
    err_count++;
    finish_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(98));
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    pll_ok <= 1'b1;
    rst_ok <= 1'b1;
    span(0, n);
    check(n, glue_pkg::SYNC_STAGES + 2);
    check(rst_n, 3'h0);
    span(1, n);
    check(n, glue_pkg::PLL_LEAD_CYCLES + 1);
    check({istrap, dstrap, soe}, {glue_pkg::ID_STRAP_INSN, glue_pkg::ID_STRAP_DATA, 1'b1});
    span(2, n);
    check(n, glue_pkg::STRAP_HOLD_CYCLES + 1);
    for (int i = 0; i < 24; i++) begin
      r = (i < 3) ? 2'(i + 1) : 2'($urandom);
      step();
      ireq <= r[1];
      dreq <= r[0];
      if (r != 2'h0) begin
        gq.push_back(r[1] ? 2'h2 : 2'h1);
      end
      step();
      ireq <= 1'b0;
      dreq <= 1'b0;
      step();
    end
    for (int w = 0; w < 5; w++) begin
      step();
      start <= 1'b1;
      waits <= 3'(w);
      repeat (w) rq.push_back(glue_pkg::REPLY_WAIT);
      rq.push_back(glue_pkg::REPLY_SUCCESS);
      step();
      start <= 1'b0;
      repeat (w + 3) step();
    end
    rst_ok <= 1'b0;
    repeat (6) step();
    check({pll, rst_n}, 6'h38);
    rst_ok <= 1'b1;
    span(1, n);
    check(n, glue_pkg::SYNC_STAGES + 2);
    check(gq.size() + rq.size(), 0);
    finish_test();
  end
endmodule
